// *** hw/ast_cfg.svh ***
// Constants of the asynchronous serial transceiver: offsets, reset values, timing.
// Assumes a 250 MHz system clock and word-aligned AHB-Lite register access.
`ifndef AST_CFG_SVH
`define AST_CFG_SVH

`define AST_CLK_HZ        250000000
`define AST_RC_TOP_BAUD   153600
`define AST_XTAL_REF_BAUD 2400
`define AST_RC_TOP_CODE   3'h7
`define AST_XTAL_REF_CODE 3'h3

`define AST_OFF_CMD       8'h00
`define AST_OFF_CTRL      8'h04
`define AST_OFF_TXDATA    8'h08
`define AST_OFF_TXSTA     8'h0c
`define AST_OFF_RXDATA    8'h10
`define AST_OFF_RXSTA     8'h14

`define AST_CMD_RESET     8'h01
`define AST_CTRL_RESET    8'h05
`define AST_DATA_RESET    8'h00
`define AST_HTRANS_NONSEQ 2'h2
`define AST_LAST_BIT8     3'h7
`define AST_LAST_BIT7     3'h6

`endif

// *** hw/ast_pkg.sv ***
// Types of the asynchronous serial transceiver.
// Assumes the constants of ast_cfg.svh for values; this file holds layouts only.
package ast_pkg;

	// Command register layout
	typedef struct packed {
		logic       spare;
		logic       clock_source_select;
		logic [2:0] rc_divider_select;
		logic       parity_mode_bit;
		logic       parity_enable_bit;
		logic       word_length_sel;
	} ast_cmd_type;

	// Control register layout
	typedef struct packed {
		logic       loopback_echo;
		logic       rx_enable_bit;
		logic       tx_enable_bit;
		logic       rx_invert;
		logic       tx_invert;
		logic [2:0] baud_code;
	} ast_ctrl_type;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ast_tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ast_rx_state_type;

endpackage

// *** hw/ast_uart.sv ***
// Asynchronous serial transceiver with an AHB-Lite register slave.
// Assumes a single slave on the bus, word accesses only, and a peer on rx_pin / tx_pin.
// What this block does
// - Clock source bit picks crystal or RC timing.
// - Divider select (RC timing only) and baud code set rate.
// - Separate enables; transmitter starts no new word when disabled.
// - Seven or eight data bits both ways.
// - Parity appended and checked when enabled.
// - Parity mode selects odd or even.
// - Optional inversion of receive and transmit lines.
// - Echo drives Tx from Rx with inversions.
// - Writing transmit data sets holding full.
// - Idle shifter loads holding word, clears full.
// - Transmit interrupt on each holding handoff.
// - Transmit busy while a word is sent.
// - Least significant bit first both ways.
// - Receive busy set on start detection.
// - Stop bit: store word, full, interrupt together.
// - Reading receive data clears holding full.
// - Unread word overwritten sets overrun flag.
// - Any write to receive status clears overrun.
// - Start fault updated at each transfer.
// - Parity fault updated at each transfer.
// - Frame fault when stop bit missing.
// - Top RC rate 153600, halving per code.
`timescale 1ns/1ps
`include "ast_cfg.svh"

module ast_uart #(
	parameter int RC_BIT_CYC   = `AST_CLK_HZ / `AST_RC_TOP_BAUD,
	parameter int XTAL_BIT_CYC = `AST_CLK_HZ / `AST_XTAL_REF_BAUD
) (
	input  wire logic        hclk,      // System clock
	input  wire logic        hresetn,   // Asynchronous reset, active low
	input  wire logic        hsel,      // Slave select
	input  wire logic [31:0] haddr,     // Byte address
	input  wire logic [1:0]  htrans,    // Transfer type
	input  wire logic        hwrite,    // Write when high
	input  wire logic [2:0]  hsize,     // Transfer size, word only
	input  wire logic        hready,    // Bus ready
	input  wire logic [31:0] hwdata,    // Write data
	output logic      [31:0] hrdata,    // Read data
	output logic             hreadyout, // Slave ready
	output logic             hresp,     // Always OKAY
	input  wire logic        rx_pin,    // Serial input pin
	output logic             tx_pin,    // Serial output pin
	output logic             tx_irq,    // Holding register handed over, pulse
	output logic             rx_irq     // Word received, pulse
);

	ast_pkg::ast_cmd_type      cmd_q;
	ast_pkg::ast_ctrl_type     ctrl_q;
	ast_pkg::ast_tx_state_type tx_st_q;
	ast_pkg::ast_rx_state_type rx_st_q;
	logic [7:0]  tx_hold_q, tx_sh_q, rx_hold_q, rx_sh_q, waddr_q;
	logic        tx_full_q, tx_par_q, rx_full_q, rx_ovr_q, wr_q;
	logic        rx_sf_q, rx_pf_q, rx_ff_q, rx_sfp_q, rx_pfp_q;
	logic [2:0]  tx_idx_q, rx_idx_q;
	logic [31:0] tx_cnt_q, rx_cnt_q, hrdata_q;
	logic        rx_s1_q, rx_s2_q, rx_s3_q, rx_f_q, rx_prev_q;
	logic        tx_pin_q, tx_irq_q, rx_irq_q;

	// Bus decode: address phase taken when selected, NONSEQ and ready
	wire         acc     = hsel && hready && (htrans == `AST_HTRANS_NONSEQ);
	wire  [7:0]  raddr   = haddr[7:0];
	wire         rd_rx   = acc && !hwrite && (raddr == `AST_OFF_RXDATA);
	wire         wr_cmd  = wr_q && (waddr_q == `AST_OFF_CMD);
	wire         wr_ctrl = wr_q && (waddr_q == `AST_OFF_CTRL);
	wire         wr_tx   = wr_q && (waddr_q == `AST_OFF_TXDATA);
	wire         wr_rxs  = wr_q && (waddr_q == `AST_OFF_RXSTA);
	wire         tx_shifting = (tx_st_q != ast_pkg::TX_IDLE);
	wire         rx_shifting = (rx_st_q != ast_pkg::RX_IDLE);
	wire  [7:0]  tx_sta  = {6'h00, tx_shifting, tx_full_q};
	wire  [7:0]  rx_sta  = {2'h0, rx_sf_q, rx_pf_q, rx_ff_q, rx_ovr_q, rx_shifting, rx_full_q};
	wire  [7:0]  rd_byte = (raddr == `AST_OFF_CMD)    ? cmd_q :
	                       (raddr == `AST_OFF_CTRL)   ? ctrl_q :
	                       (raddr == `AST_OFF_TXDATA) ? tx_hold_q :
	                       (raddr == `AST_OFF_TXSTA)  ? tx_sta :
	                       (raddr == `AST_OFF_RXDATA) ? rx_hold_q :
	                       (raddr == `AST_OFF_RXSTA)  ? rx_sta : 8'h00;

	// Bit period: RC path doubles per code step below 7 and per divider step, crystal path from its 2400 baud point
	wire  [2:0]  br       = ctrl_q.baud_code;
	wire  [3:0]  rc_shift = {1'b0, `AST_RC_TOP_CODE - br} + {1'b0, cmd_q.rc_divider_select};
	wire  [2:0]  xt_shift = (br > `AST_XTAL_REF_CODE) ? 3'h0 : `AST_XTAL_REF_CODE - br;
	wire  [31:0] rc_cyc   = 32'(RC_BIT_CYC) << rc_shift;
	wire  [31:0] xt_cyc   = 32'(XTAL_BIT_CYC) << xt_shift;
	wire  [31:0] bit_cyc  = cmd_q.clock_source_select ? xt_cyc : rc_cyc;
	wire  [31:0] half_cyc = {1'b0, bit_cyc[31:1]};
	// Frame shape shared by both directions
	wire         wl8      = cmd_q.word_length_sel;
	wire  [2:0]  last_bit = wl8 ? `AST_LAST_BIT8 : `AST_LAST_BIT7;
	wire  [7:0]  tx_word  = wl8 ? tx_hold_q : {1'b0, tx_hold_q[6:0]};
	wire         tx_par   = (^tx_word) ^ cmd_q.parity_mode_bit;
	// Transmit line before inversion
	wire         tx_tick     = (tx_cnt_q == 32'h0);
	wire         tx_load     = !tx_shifting && ctrl_q.tx_enable_bit && tx_full_q;
	wire         tx_line     = (tx_st_q == ast_pkg::TX_START)  ? 1'b0 :
	                           (tx_st_q == ast_pkg::TX_DATA)   ? tx_sh_q[0] :
	                           (tx_st_q == ast_pkg::TX_PARITY) ? tx_par_q : 1'b1;
	// Receive decode on the filtered, optionally inverted line
	wire         rx_in       = rx_f_q ^ ctrl_q.rx_invert;
	wire         rx_tick     = (rx_cnt_q == 32'h0);
	wire  [7:0]  rx_word     = wl8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
	wire         rx_pexp     = (^rx_word) ^ cmd_q.parity_mode_bit;
	wire         rx_xfer     = (rx_st_q == ast_pkg::RX_STOP) && rx_tick;
	wire         rx_go       = !rx_shifting && ctrl_q.rx_enable_bit && rx_prev_q && !rx_in;
	// Bus outputs: zero wait, always OKAY, read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q     <= 1'b0;
			waddr_q  <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q    <= acc && hwrite;
			waddr_q <= raddr;
			if (acc && !hwrite)
				hrdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Configuration registers, written in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmd_q  <= `AST_CMD_RESET;
			ctrl_q <= `AST_CTRL_RESET;
		end
		else
		begin
			if (wr_cmd)
				cmd_q <= hwdata[7:0];
			if (wr_ctrl)
				ctrl_q <= hwdata[7:0];
		end
	end

	// Rx pin synchroniser; a level counts once the second and third stages agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_f_q  <= 1'b1;
			rx_prev_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q)
				rx_f_q <= rx_s3_q;
			rx_prev_q <= rx_in; // Only a high-to-low change starts a frame, so a low stop bit starts none
		end
	end

	// Holding register and its full flag; a write in the load cycle keeps the flag set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_hold_q <= `AST_DATA_RESET;
			tx_full_q <= 1'b0;
		end
		else if (wr_tx)
		begin
			tx_hold_q <= hwdata[7:0];
			tx_full_q <= 1'b1;
		end
		else if (tx_load)
			tx_full_q <= 1'b0;
	end

	// Transmit shifter; a word in flight finishes even if the enable drops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_st_q  <= ast_pkg::TX_IDLE;
			tx_sh_q  <= `AST_DATA_RESET;
			tx_par_q <= 1'b0;
			tx_idx_q <= 3'h0;
			tx_cnt_q <= 32'h0;
		end
		else
		begin
			tx_cnt_q <= tx_tick ? bit_cyc - 32'h1 : tx_cnt_q - 32'h1;
			case (tx_st_q)
				ast_pkg::TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_st_q  <= ast_pkg::TX_START;
						tx_sh_q  <= tx_word;
						tx_par_q <= tx_par;
						tx_cnt_q <= bit_cyc - 32'h1;
					end
				end
				ast_pkg::TX_START:
				begin
					if (tx_tick)
					begin
						tx_st_q  <= ast_pkg::TX_DATA;
						tx_idx_q <= 3'h0;
					end
				end
				ast_pkg::TX_DATA:
				begin
					if (tx_tick)
					begin
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
						tx_idx_q <= tx_idx_q + 3'h1;
						if (tx_idx_q == last_bit)
							tx_st_q <= cmd_q.parity_enable_bit ? ast_pkg::TX_PARITY : ast_pkg::TX_STOP;
					end
				end
				ast_pkg::TX_PARITY:
				begin
					if (tx_tick)
						tx_st_q <= ast_pkg::TX_STOP;
				end
				ast_pkg::TX_STOP:
				begin
					if (tx_tick)
						tx_st_q <= ast_pkg::TX_IDLE;
				end
				default:
					tx_st_q <= ast_pkg::TX_IDLE;
			endcase
		end
	end

	// Pin and interrupt outputs, each straight from a flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_pin_q <= 1'b1;
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end
		else
		begin
			tx_pin_q <= ctrl_q.loopback_echo ? rx_in ^ ctrl_q.tx_invert : tx_line ^ ctrl_q.tx_invert;
			tx_irq_q <= tx_load;
			rx_irq_q <= rx_xfer;
		end
	end

	// Receive shifter; start fault kept pending so it is reported with the word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_st_q  <= ast_pkg::RX_IDLE;
			rx_sh_q  <= `AST_DATA_RESET;
			rx_idx_q <= 3'h0;
			rx_cnt_q <= 32'h0;
			rx_sfp_q <= 1'b0;
			rx_pfp_q <= 1'b0;
		end
		else
		begin
			rx_cnt_q <= rx_tick ? bit_cyc - 32'h1 : rx_cnt_q - 32'h1;
			case (rx_st_q)
				ast_pkg::RX_IDLE:
				begin
					if (rx_go)
					begin
						rx_st_q  <= ast_pkg::RX_START;
						rx_cnt_q <= half_cyc;
						rx_sfp_q <= 1'b0;
						rx_pfp_q <= 1'b0;
					end
				end
				ast_pkg::RX_START:
				begin
					if (rx_tick)
					begin
						rx_sfp_q <= rx_in;
						rx_idx_q <= 3'h0;
						rx_st_q  <= ast_pkg::RX_DATA;
					end
				end
				ast_pkg::RX_DATA:
				begin
					if (rx_tick)
					begin
						rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
						rx_idx_q <= rx_idx_q + 3'h1;
						if (rx_idx_q == last_bit)
							rx_st_q <= cmd_q.parity_enable_bit ? ast_pkg::RX_PARITY : ast_pkg::RX_STOP;
					end
				end
				ast_pkg::RX_PARITY:
				begin
					if (rx_tick)
					begin
						rx_pfp_q <= rx_in ^ rx_pexp;
						rx_st_q  <= ast_pkg::RX_STOP;
					end
				end
				ast_pkg::RX_STOP:
				begin
					if (rx_tick)
						rx_st_q <= ast_pkg::RX_IDLE;
				end
				default:
					rx_st_q <= ast_pkg::RX_IDLE;
			endcase
			if (!ctrl_q.rx_enable_bit)
				rx_st_q <= ast_pkg::RX_IDLE;
		end
	end

	// Receive holding register and status; hardware set wins over software clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_hold_q <= `AST_DATA_RESET;
			rx_full_q <= 1'b0;
			rx_ovr_q  <= 1'b0;
			rx_sf_q   <= 1'b0;
			rx_pf_q   <= 1'b0;
			rx_ff_q   <= 1'b0;
		end
		else if (rx_xfer)
		begin
			rx_hold_q <= rx_word;
			rx_full_q <= 1'b1;
			rx_sf_q   <= rx_sfp_q;
			rx_pf_q   <= rx_pfp_q;
			rx_ff_q   <= !rx_in;
			if (rx_full_q && !rd_rx)
				rx_ovr_q <= 1'b1;
			else if (wr_rxs)
				rx_ovr_q <= 1'b0;
		end
		else
		begin
			if (rd_rx)
				rx_full_q <= 1'b0;
			if (wr_rxs)
				rx_ovr_q <= 1'b0;
		end
	end
	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign tx_pin    = tx_pin_q;
	assign tx_irq    = tx_irq_q;
	assign rx_irq    = rx_irq_q;
	// Checks on the transmit side
	tx_handoff_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_irq_q |-> $past(tx_full_q) && !$past(tx_shifting) && tx_shifting)
		else $error("tx interrupt without a handoff");
	full_on_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_tx |=> tx_full_q && tx_hold_q == $past(hwdata[7:0]))
		else $error("tx write did not fill holding register");
	tx_disabled_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!tx_shifting && !ctrl_q.tx_enable_bit |=> !tx_shifting)
		else $error("transmitter started while disabled");
	start_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(tx_shifting) && !ctrl_q.loopback_echo && !ctrl_q.tx_invert |=> !tx_pin_q)
		else $error("start bit not low");
	echo_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_q.loopback_echo |=> tx_pin_q == ($past(rx_f_q) ^ $past(ctrl_q.rx_invert) ^ $past(ctrl_q.tx_invert)))
		else $error("echo output mismatch");
	// Checks on the receive side
	rx_transfer_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_xfer |=> rx_full_q && rx_irq_q && !rx_shifting)
		else $error("receive transfer incomplete");
	overrun_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_xfer && rx_full_q && !rd_rx |=> rx_ovr_q)
		else $error("overrun not flagged");
	overrun_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_rxs && !rx_xfer |=> !rx_ovr_q)
		else $error("overrun not cleared by status write");
	read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_rx && !rx_xfer |=> !rx_full_q)
		else $error("read did not clear receive full");
	rx_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_go |=> rx_shifting)
		else $error("receive busy not set on start");
	tx_word_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(tx_shifting));
	rx_word_c: cover property (@(posedge hclk) disable iff (!hresetn) rx_xfer && rx_pfp_q);
	overrun_c: cover property (@(posedge hclk) disable iff (!hresetn) rx_xfer && rx_full_q);
endmodule

// *** tb/ast_peer.sv ***
// Remote serial peer: drives the device receive pin, decodes its transmit pin.
// Assumes the bench gives the bit period in clock cycles and calls tasks just after a rising edge.
`timescale 1ns/1ps

module ast_peer (
	input  wire logic hclk,   // Bench clock
	output logic      line_o, // To the device receive pin
	input  wire logic line_i  // From the device transmit pin
);
	// Line idles high; the peer never lets it float
	initial line_o = 1'b1;

	// Hold one level for a whole bit period
	task bit_out(input logic v, input int bc);
		line_o <= v;
		repeat (bc) @(posedge hclk);
	endtask

	// Send one frame; parity is passed in so the bench can send a wrong one
	task send(input logic [7:0] d, input int nb, input logic pe, input logic p, input logic bad_s, input int bc);
		bit_out(1'b0, bc);
		for (int i = 0; i < nb; i++)
			bit_out(d[i], bc);
		if (pe)
			bit_out(p, bc);
		bit_out(!bad_s, bc);
		bit_out(1'b1, bc);
	endtask

	// Sample at bit centres; q is stop, parity, data from the top down
	task capture(input int nb, input logic pe, input int bc, output logic [9:0] q);
		q = 10'h000;
		while (line_i !== 1'b0)
			@(posedge hclk);
		repeat (bc / 2) @(posedge hclk);
		for (int i = 0; i < nb; i++)
		begin
			repeat (bc) @(posedge hclk);
			q[i] = line_i;
		end
		if (pe)
		begin
			repeat (bc) @(posedge hclk);
			q[8] = line_i;
		end
		repeat (bc) @(posedge hclk);
		q[9] = line_i;
	endtask

	// Hold a static level, used for the echo path
	task level(input logic v);
		line_o <= v;
	endtask
endmodule

// *** tb/async_serial_transceiver_bench.sv ***
// Self-checking bench of the serial transceiver over AHB-Lite and a serial peer.
// Assumes the short bit periods set below: 16 cycles at the top RC rate, 32 for the crystal.
`timescale 1ns/1ps
`include "ast_cfg.svh"

module async_serial_transceiver_bench;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b0;
	logic             hwrite = 1'b0;
	logic [1:0]       htrans = 2'h0;
	logic [31:0]      haddr = 32'h0;
	logic [31:0]      hwdata = 32'h0;
	logic [31:0]      q;
	logic [31:0]      seed = 32'h82e984c1;
	logic [9:0]       cap;
	logic [7:0]       cmd;
	logic [7:0]       ctrl;
	logic             pe;
	logic             odd;
	int               nb;
	int               bc;
	wire logic [31:0] hrdata;
	wire logic        hreadyout;
	wire logic        hresp;
	wire logic        rx_pin;
	wire logic        tx_pin;
	wire logic        tx_irq;
	wire logic        rx_irq;
	int               n_mismatch = 0;
	int               samples_checked = 0;
	int               n_txi = 0;
	int               n_rxi = 0;
	int               cyc = 0;

	// 250 MHz clock
	always #2 hclk = ~hclk;

	ast_uart #(.RC_BIT_CYC(16), .XTAL_BIT_CYC(32)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.tx_irq(tx_irq), .rx_irq(rx_irq));

	ast_peer peer_u (.hclk(hclk), .line_o(rx_pin), .line_i(tx_pin));

	// Count interrupt pulses; a pulse stuck high shows up as extra counts
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		n_txi <= n_txi + int'(tx_irq === 1'b1);
		n_rxi <= n_rxi + int'(rx_irq === 1'b1);
		if (cyc == 40000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Parity bit over the sent data bits
	function logic par(input logic [7:0] d, input int nb, input logic odd);
		return (nb == 8 ? ^d : ^d[6:0]) ^ odd;
	endfunction

	task chk(input string name, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", name, e, g);
		end
	endtask

	task report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One single transfer; the caller stands just after a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= `AST_HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask

	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask

	// Start a transmission by writing d at a and decode the frame seen on the pin
	task tx_one(input logic [7:0] a, input logic [7:0] d, input logic [7:0] x, input int nb, input logic pe,
		input logic odd, input int bc);
		int t0;
		t0 = n_txi;
		bus(1'b0, `AST_OFF_TXSTA, 32'h0);
		while (q[1] !== 1'b0)
			bus(1'b0, `AST_OFF_TXSTA, 32'h0);
		fork
			peer_u.capture(nb, pe, bc, cap);
			begin
				bus(1'b1, a, {24'h0, d});
				repeat (4) @(posedge hclk);
				rdc("tx status", `AST_OFF_TXSTA, 32'h2);
			end
		join
		chk("tx word", {24'h0, x}, {24'h0, cap[7:0]});
		chk("tx parity", {31'h0, pe & par(x, nb, odd)}, {31'h0, cap[8]});
		chk("tx stop", 32'h1, {31'h0, cap[9]});
		chk("tx irq", t0 + 1, n_txi);
	endtask

	// Peer sends one frame; check status, word, then that the read cleared full
	task rx_one(input logic [7:0] d, input int nb, input logic pe, input logic odd, input logic bad_p,
		input logic bad_s, input int bc, input logic [7:0] sta);
		int t0;
		t0 = n_rxi;
		peer_u.send(d, nb, pe, par(d, nb, odd) ^ bad_p, bad_s, bc);
		chk("rx irq", t0 + 1, n_rxi);
		rdc("rx status", `AST_OFF_RXSTA, {24'h0, sta});
		rdc("rx word", `AST_OFF_RXDATA, nb == 8 ? {24'h0, d} : {25'h0, d[6:0]});
		rdc("rx cleared", `AST_OFF_RXSTA, {24'h0, sta & 8'hfe});
	endtask

	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values; offset 0x18 is unmapped
		for (int i = 0; i < 7; i++)
			rdc("reset value", 8'(4 * i), i == 0 ? 32'h1 : (i == 1 ? 32'h5 : 32'h0));
		$display("test reset done");
		// The holding word waits while the transmitter is off
		bus(1'b1, `AST_OFF_CTRL, 32'h47);
		bus(1'b1, `AST_OFF_TXDATA, 32'ha5);
		repeat (40) @(posedge hclk);
		rdc("tx held", `AST_OFF_TXSTA, 32'h1);
		chk("tx idle", 32'h1, {31'h0, tx_pin});
		tx_one(`AST_OFF_CTRL, 8'h67, 8'ha5, 8, 1'b0, 1'b0, 16);
		$display("test tx enable done");
		// Random words over word length, parity and clock settings
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			nb = seed[0] ? 8 : 7;
			pe = seed[1];
			odd = seed[2];
			bc = (i % 4 == 0) ? 16 : 32;
			cmd = {1'b0, i % 4 == 3, (i % 4 == 2) ? 3'h1 : 3'h0, odd, pe, seed[0]};
			ctrl = (i % 4 == 1) ? 8'h66 : ((i % 4 == 3) ? 8'h63 : 8'h67);
			bus(1'b1, `AST_OFF_CMD, {24'h0, cmd});
			bus(1'b1, `AST_OFF_CTRL, {24'h0, ctrl});
			tx_one(`AST_OFF_TXDATA, seed[15:8], nb == 8 ? seed[15:8] : {1'b0, seed[14:8]}, nb, pe, odd, bc);
			rx_one(seed[23:16], nb, pe, odd, 1'b0, 1'b0, bc, 8'h01);
		end
		$display("test random done");
		// Faults are refreshed at every transfer
		bus(1'b1, `AST_OFF_CMD, 32'h3);
		bus(1'b1, `AST_OFF_CTRL, 32'h67);
		rx_one(8'h3c, 8, 1'b1, 1'b0, 1'b1, 1'b0, 16, 8'h11);
		rx_one(8'hc3, 8, 1'b1, 1'b0, 1'b0, 1'b1, 16, 8'h09);
		// A short low pulse starts a frame whose start bit reads high at its centre
		peer_u.level(1'b0);
		repeat (2) @(posedge hclk);
		peer_u.level(1'b1);
		repeat (250) @(posedge hclk);
		rdc("start fault", `AST_OFF_RXSTA, 32'h31);
		rdc("glitch word", `AST_OFF_RXDATA, 32'hff);
		rx_one(8'h5a, 8, 1'b1, 1'b0, 1'b0, 1'b0, 16, 8'h01);
		peer_u.send(8'h11, 8, 1'b1, par(8'h11, 8, 1'b0), 1'b0, 16);
		peer_u.send(8'h22, 8, 1'b1, par(8'h22, 8, 1'b0), 1'b0, 16);
		rdc("overrun set", `AST_OFF_RXSTA, 32'h5);
		bus(1'b1, `AST_OFF_RXSTA, 32'h0);
		rdc("overrun cleared", `AST_OFF_RXSTA, 32'h1);
		rdc("overrun word", `AST_OFF_RXDATA, 32'h22);
		$display("test faults done");
		// Echo path under every inversion setting, receiver off
		for (int k = 0; k < 4; k++)
		begin
			bus(1'b1, `AST_OFF_CTRL, 32'ha7 | (k << 3));
			for (int v = 0; v < 2; v++)
			begin
				peer_u.level(v[0]);
				repeat (10) @(posedge hclk);
				chk("echo", {31'h0, v[0] ^ k[0] ^ k[1]}, {31'h0, tx_pin});
			end
		end
		$display("test echo done");
		report_and_stop();
	end
endmodule
